// >>> rtl/acalu_regs.svh
// Function
// - test-select field picks never, always, carry/result zero or nonzero, either, both
// - skip equals sk bit 0 xor (sk2 and result zero or sk1 and carry zero)
// - suppress-writeback set loads neither target accumulator nor carry flag
// - op 0 inverts source, carry passes
// - op 1 negates source, carry inverted only when source is zero
// - op 2 passes source and carry
// - op 3 increments source, carry inverted when source is all ones
// - op 4 adds target and inverted source; ops 4-6 invert carry on adder carry
// - op 5 subtracts source from target
// - op 6 adds source and target
// - op 7 ands source and target, carry passes
// - misc range decoded by bits 8-12 into 32 opcodes, bits 0-7 displacement
// - one misc opcode uses displacement as sub-opcode; only 10h (multiply) and 11h (divide) are decoded, others trap
// - memory trap stores next pc at return slot, jumps through pointer table
// - pointer table has 32 words, one per misc opcode in order
// - with control RAM trap enters RAM entry with instruction and swapped copy
// - multiply AC1 by AC2 plus AC0, high in AC0, low in AC1
// - divide AC0:AC1 by AC2, quotient AC1, remainder AC0, skip unless overflow
// - rotate AC0 left by instruction count, or by AC1 low bits if zero
// - double-indirect calls save pc plus one in AC3, load pc twice indirect
// - carry-input field: flag, zero, one, inverted flag
// - rotator field: pass, rotate left, rotate right, swap bytes keep carry
`ifndef ACALU_REGS_SVH
`define ACALU_REGS_SVH
// bus byte offsets
`define ACALU_A_AC0 8'h00
`define ACALU_A_AC1 8'h04
`define ACALU_A_AC2 8'h08
`define ACALU_A_AC3 8'h0C
`define ACALU_A_PC 8'h10
`define ACALU_A_CARRY 8'h14
`define ACALU_A_INSTR 8'h18
`define ACALU_A_STATUS 8'h1C
`define ACALU_A_CTRL 8'h20
`define ACALU_A_LREG 8'h24
`define ACALU_A_SWAPPED_INSTR_REG 8'h28
// instruction fields (bit 15 is the leftmost bit)
`define ACALU_F_ARITH 15
`define ACALU_F_SRC 14:13
`define ACALU_F_DST 12:11
`define ACALU_F_OP 10:8
`define ACALU_F_SH 7:6
`define ACALU_F_CY 5:4
`define ACALU_F_NL 3
`define ACALU_F_SK 2:0
`define ACALU_F_GRP 15:13
`define ACALU_F_MOP 12:8
`define ACALU_F_DISP 7:0
`define ACALU_F_CNT 3:0
`define ACALU_GRP_MISC 3'h3
// misc opcodes and sub-opcodes
`define ACALU_M_ROTL 5'h00
`define ACALU_M_SUB 5'h02
`define ACALU_M_CALLPC 5'h09
`define ACALU_M_CALLB 5'h0A
`define ACALU_S_MUL 8'h10
`define ACALU_S_DIV 8'h11
// memory locations
`define ACALU_TRAP_RET 16'h0157
`define ACALU_TRAP_TAB 16'h0158
`define ACALU_RST_WORD 16'h0000
`endif

// >>> rtl/acalu_pkg.sv
package acalu_pkg;
  typedef enum logic [3:0] {
    ACALU_IDLE = 4'b0001,
    ACALU_WRET = 4'b0010,
    ACALU_RD1 = 4'b0100,
    ACALU_RD2 = 4'b1000
  } acalu_state_t;
endpackage

// >>> rtl/acalu_core.sv
`timescale 1ns/1ns
`include "acalu_regs.svh"
module acalu_core #(
  parameter int WORD_W = 16
) (
  input wire logic mclk_i, // 25 MHz clock
  input wire logic rstn_i, // sync reset, active low
  input wire logic hsel_i, // ahb select
  input wire logic [31:0] haddr_i, // ahb address
  input wire logic [1:0] htrans_i, // ahb transfer type
  input wire logic hwrite_i, // ahb write
  input wire logic [2:0] hsize_i, // ahb size, word only
  input wire logic [31:0] hwdata_i, // ahb write data
  input wire logic hready_i, // ahb bus ready
  output logic [31:0] hrdata_o, // ahb read data
  output logic hreadyout_o, // ahb slave ready
  output logic hresp_o, // ahb response, always okay
  output logic mem_req_o, // memory request
  output logic mem_we_o, // memory write
  output logic [15:0] mem_addr_o, // memory word address
  output logic [15:0] mem_wdata_o, // memory write data
  input wire logic [15:0] mem_rdata_i, // memory read data
  input wire logic mem_ack_i // memory access done
);
  if (WORD_W != 16) begin : g_word_chk
    $error("acalu_core supports only 16-bit words");
  end

  // ****************************************
  // bus slave
  // ****************************************
  logic dp_rd_r, dp_wr_r, rd_ok_r;
  logic [7:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic [15:0] ac_r [4];
  logic [15:0] pc_r, ir_r, l_r, x_r;
  logic carry_r, go_r, ram_present_r, ram_trap_r, skip_r, busy;
  acalu_pkg::acalu_state_t st_r;
  logic [31:0] rd_val;
  logic wr_en, addr_ph;

  assign busy = go_r || (st_r != acalu_pkg::ACALU_IDLE);
  // reads take one wait state so hrdata comes from a flop
  assign hreadyout_o = !(dp_rd_r && !rd_ok_r) &&
                       !(dp_wr_r && dp_addr_r == `ACALU_A_INSTR && busy);
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_r;
  assign addr_ph = hsel_i && htrans_i[1] && hready_i;
  assign wr_en = dp_wr_r && hreadyout_o;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      dp_rd_r <= 1'b0;
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (hready_i) begin
      dp_rd_r <= addr_ph && !hwrite_i;
      dp_wr_r <= addr_ph && hwrite_i;
      dp_addr_r <= haddr_i[7:0];
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (dp_addr_r)
      `ACALU_A_AC0: rd_val[15:0] = ac_r[0];
      `ACALU_A_AC1: rd_val[15:0] = ac_r[1];
      `ACALU_A_AC2: rd_val[15:0] = ac_r[2];
      `ACALU_A_AC3: rd_val[15:0] = ac_r[3];
      `ACALU_A_PC: rd_val[15:0] = pc_r;
      `ACALU_A_CARRY: rd_val[0] = carry_r;
      `ACALU_A_INSTR: rd_val[15:0] = ir_r;
      `ACALU_A_STATUS: rd_val[2:0] = {skip_r, ram_trap_r, busy};
      `ACALU_A_CTRL: rd_val[0] = ram_present_r;
      `ACALU_A_LREG: rd_val[15:0] = l_r;
      `ACALU_A_SWAPPED_INSTR_REG: rd_val[15:0] = x_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rd_ok_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      rd_ok_r <= dp_rd_r && !rd_ok_r;
      if (dp_rd_r && !rd_ok_r) begin
        hrdata_r <= rd_val;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ram_present_r <= 1'b0;
    end else if (wr_en && dp_addr_r == `ACALU_A_CTRL) begin
      ram_present_r <= hwdata_i[0];
    end
  end

  // ****************************************
  // arithmetic datapath
  // ****************************************
  logic [15:0] src, dst, res, rot_res;
  logic cin, cout, rot_c, skip_ar;
  logic [16:0] sum;
  logic [16:0] rot_w;
  logic [2:0] sk;

  assign src = ac_r[ir_r[`ACALU_F_SRC]];
  assign dst = ac_r[ir_r[`ACALU_F_DST]];

  always_comb begin
    unique case (ir_r[`ACALU_F_CY])
      2'd0: cin = carry_r;
      2'd1: cin = 1'b0;
      2'd2: cin = 1'b1;
      default: cin = !carry_r;
    endcase
  end

  always_comb begin
    sum = 17'h0_0000;
    res = 16'h0000;
    cout = cin;
    unique case (ir_r[`ACALU_F_OP])
      3'd0: res = ~src;
      3'd1: begin
        res = 16'(~src + 16'h0001);
        cout = (src == 16'h0000) ? !cin : cin;
      end
      3'd2: res = src;
      3'd3: begin
        res = 16'(src + 16'h0001);
        cout = (src == 16'hFFFF) ? !cin : cin;
      end
      3'd4: sum = {1'b0, dst} + {1'b0, ~src};
      3'd5: sum = {1'b0, dst} + {1'b0, ~src} + 17'h0_0001;
      3'd6: sum = {1'b0, dst} + {1'b0, src};
      default: res = src & dst;
    endcase
    if (ir_r[`ACALU_F_OP] inside {3'd4, 3'd5, 3'd6}) begin
      res = sum[15:0];
      cout = cin ^ sum[16];
    end
  end

  always_comb begin
    unique case (ir_r[`ACALU_F_SH])
      2'd0: rot_w = {cout, res};
      2'd1: rot_w = {res, cout};
      2'd2: rot_w = {res[0], cout, res[15:1]};
      default: rot_w = {cout, res[7:0], res[15:8]};
    endcase
  end
  assign rot_res = rot_w[15:0];
  assign rot_c = rot_w[16];
  // skip sensor, sk[2] is the field's first bit
  assign sk = ir_r[`ACALU_F_SK];
  assign skip_ar = sk[0] ^ ((sk[2] && rot_res == 16'h0000) || (sk[1] && !rot_c));

  // ****************************************
  // misc group
  // ****************************************
  logic is_arith, is_misc, do_rotl, do_mul, do_div, do_call, do_trap;
  logic [4:0] mop;
  logic [3:0] cnt;
  logic [31:0] prod, dividend, quo, rem, rotl2;
  logic [15:0] sdisp, base, pc1, pc_word;
  logic div_ovf;

  assign is_arith = ir_r[`ACALU_F_ARITH];
  assign is_misc = ir_r[`ACALU_F_GRP] == `ACALU_GRP_MISC;
  assign mop = ir_r[`ACALU_F_MOP];
  assign do_rotl = is_misc && mop == `ACALU_M_ROTL;
  assign do_mul = is_misc && mop == `ACALU_M_SUB && ir_r[`ACALU_F_DISP] == `ACALU_S_MUL;
  assign do_div = is_misc && mop == `ACALU_M_SUB && ir_r[`ACALU_F_DISP] == `ACALU_S_DIV;
  assign do_call = is_misc && (mop == `ACALU_M_CALLPC || mop == `ACALU_M_CALLB);
  assign do_trap = !is_arith && !do_rotl && !do_mul && !do_div && !do_call;

  assign prod = ac_r[1] * ac_r[2] + {16'h0000, ac_r[0]};
  // divide, overflow when high word not below divisor
  assign dividend = {ac_r[0], ac_r[1]};
  assign div_ovf = ac_r[0] >= ac_r[2];
  assign quo = div_ovf ? 32'h0000_0000 : dividend / {16'h0000, ac_r[2]};
  assign rem = div_ovf ? 32'h0000_0000 : dividend % {16'h0000, ac_r[2]};
  assign cnt = (ir_r[`ACALU_F_CNT] != 4'h0) ? ir_r[`ACALU_F_CNT] : ac_r[1][`ACALU_F_CNT];
  assign rotl2 = {ac_r[0], ac_r[0]} << cnt;
  assign sdisp = {{8{ir_r[7]}}, ir_r[`ACALU_F_DISP]};
  assign pc1 = 16'(pc_r + 16'h0001);
  assign base = 16'((mop == `ACALU_M_CALLPC ? pc_r : ac_r[2]) + sdisp);

  // ****************************************
  // sequencer and architectural state
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      go_r <= 1'b0;
      ir_r <= `ACALU_RST_WORD;
    end else begin
      go_r <= wr_en && dp_addr_r == `ACALU_A_INSTR;
      if (wr_en && dp_addr_r == `ACALU_A_INSTR) begin
        ir_r <= hwdata_i[15:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st_r <= acalu_pkg::ACALU_IDLE;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= `ACALU_RST_WORD;
      mem_wdata_o <= `ACALU_RST_WORD;
    end else begin
      unique case (st_r)
        acalu_pkg::ACALU_IDLE: begin
          if (go_r && do_trap && !ram_present_r) begin
            st_r <= acalu_pkg::ACALU_WRET;
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_addr_o <= `ACALU_TRAP_RET;
            mem_wdata_o <= pc1;
          end else if (go_r && do_call) begin
            st_r <= acalu_pkg::ACALU_RD1;
            mem_req_o <= 1'b1;
            mem_addr_o <= base;
          end
        end
        acalu_pkg::ACALU_WRET: begin
          if (mem_ack_i) begin
            st_r <= acalu_pkg::ACALU_RD2;
            mem_we_o <= 1'b0;
            mem_addr_o <= 16'(`ACALU_TRAP_TAB + {11'h000, mop});
          end
        end
        acalu_pkg::ACALU_RD1: begin
          if (mem_ack_i) begin
            st_r <= acalu_pkg::ACALU_RD2;
            mem_addr_o <= mem_rdata_i;
          end
        end
        acalu_pkg::ACALU_RD2: begin
          if (mem_ack_i) begin
            st_r <= acalu_pkg::ACALU_IDLE;
            mem_req_o <= 1'b0;
          end
        end
      endcase
    end
  end

  assign pc_word = mem_rdata_i;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 4; i++) begin
        ac_r[i] <= `ACALU_RST_WORD;
      end
      pc_r <= `ACALU_RST_WORD;
      carry_r <= 1'b0;
      skip_r <= 1'b0;
    end else if (go_r) begin
      skip_r <= 1'b0;
      pc_r <= pc1;
      if (is_arith) begin
        if (!ir_r[`ACALU_F_NL]) begin
          ac_r[ir_r[`ACALU_F_DST]] <= rot_res;
          carry_r <= rot_c;
        end
        skip_r <= skip_ar;
        pc_r <= 16'(pc_r + 16'h0001 + {15'h0000, skip_ar});
      end else if (do_mul) begin
        ac_r[0] <= prod[31:16];
        ac_r[1] <= prod[15:0];
      end else if (do_div && !div_ovf) begin
        ac_r[0] <= rem[15:0];
        ac_r[1] <= quo[15:0];
        skip_r <= 1'b1;
        pc_r <= 16'(pc_r + 16'h0002);
      end else if (do_rotl) begin
        ac_r[0] <= rotl2[31:16];
      end else if (do_call) begin
        ac_r[3] <= pc1;
      end
    end else if (st_r == acalu_pkg::ACALU_RD2 && mem_ack_i) begin
      pc_r <= pc_word;
    end else if (wr_en && !busy) begin
      unique case (dp_addr_r)
        `ACALU_A_AC0: ac_r[0] <= hwdata_i[15:0];
        `ACALU_A_AC1: ac_r[1] <= hwdata_i[15:0];
        `ACALU_A_AC2: ac_r[2] <= hwdata_i[15:0];
        `ACALU_A_AC3: ac_r[3] <= hwdata_i[15:0];
        `ACALU_A_PC: pc_r <= hwdata_i[15:0];
        `ACALU_A_CARRY: carry_r <= hwdata_i[0];
        default: skip_r <= skip_r;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      l_r <= `ACALU_RST_WORD;
      x_r <= `ACALU_RST_WORD;
      ram_trap_r <= 1'b0;
    end else if (go_r) begin
      ram_trap_r <= do_trap && ram_present_r;
      if (do_trap && ram_present_r) begin
        l_r <= ir_r;
        x_r <= {ir_r[7:0], ir_r[15:8]};
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  property p_skip_pc;
    go_r && is_arith |=> pc_r == 16'($past(pc_r) + 16'h0001 + {15'h0000, skip_r});
  endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("pc step wrong");

  property p_sk_never;
    go_r && is_arith && ir_r[`ACALU_F_SK] == 3'd0 |=> !skip_r;
  endproperty
  a_sk_never: assert property (p_sk_never) else $error("skip with never");

  property p_sk_eq;
    go_r && is_arith && ir_r[`ACALU_F_SK] == 3'd4 |=> skip_r == ($past(rot_res) == 16'h0000);
  endproperty
  a_sk_eq: assert property (p_sk_eq) else $error("zero-result skip wrong");

  property p_nl;
    go_r && is_arith && ir_r[`ACALU_F_NL] |=> $stable(carry_r) && $stable(dst);
  endproperty
  a_nl: assert property (p_nl) else $error("suppressed writeback loaded");

  property p_cy_zero;
    go_r && is_arith && ir_r[10:4] == 7'h21 && !ir_r[`ACALU_F_NL] |=> !carry_r;
  endproperty
  a_cy_zero: assert property (p_cy_zero) else $error("carry zero select failed");

  property p_mul;
    go_r && do_mul |=> {ac_r[0], ac_r[1]} == $past(prod) && $stable(ac_r[2]);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply wrong");

  property p_div_ovf;
    go_r && do_div && div_ovf |=> !skip_r && $stable(ac_r[1]);
  endproperty
  a_div_ovf: assert property (p_div_ovf) else $error("overflow divide skipped");

  property p_trap;
    go_r && do_trap && !ram_present_r |=> mem_req_o && mem_we_o && mem_addr_o == `ACALU_TRAP_RET
      && mem_wdata_o == 16'($past(pc_r) + 16'h0001);
  endproperty
  a_trap: assert property (p_trap) else $error("trap save wrong");

  property p_ram_trap;
    go_r && do_trap && ram_present_r |=> ram_trap_r && l_r == $past(ir_r)
      && x_r == {l_r[7:0], l_r[15:8]} && !mem_req_o;
  endproperty
  a_ram_trap: assert property (p_ram_trap) else $error("ram trap wrong");

  property p_call;
    go_r && do_call |=> ac_r[3] == pc_r && mem_addr_o == $past(base);
  endproperty
  a_call: assert property (p_call) else $error("call setup wrong");
endmodule

// >>> verification/acalu_mem.sv
`timescale 1ns/1ns
module acalu_mem (
  input wire logic mclk_i, // clock
  input wire logic rstn_i, // sync reset, active low
  input wire logic mem_req_i, // access request
  input wire logic mem_we_i, // write
  input wire logic [15:0] mem_addr_i, // word address
  input wire logic [15:0] mem_wdata_i, // write data
  input wire logic [1:0] dly_i, // wait cycles before ack
  output logic [15:0] mem_rdata_o, // read data
  output logic mem_ack_o // access done pulse
);
  // ****
  // word memory
  // ****
  logic [15:0] mem [0:65535];
  logic [1:0] cnt_r;
  initial begin
    mem_rdata_o = 16'h0000;
    mem_ack_o = 1'b0;
    cnt_r = 2'h0;
  end
  // data flips outside read acks so a stale word never looks valid
  always @(posedge mclk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (!rstn_i) begin
      cnt_r <= 2'h0;
    end else if (mem_req_i && !mem_ack_o) begin
      if (cnt_r == dly_i) begin
        mem_ack_o <= 1'b1;
        cnt_r <= 2'h0;
        if (mem_we_i) begin
          mem[mem_addr_i] <= mem_wdata_i;
        end else begin
          mem_rdata_o <= mem[mem_addr_i];
        end
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ns
`include "acalu_regs.svh"
module testbench;
  typedef struct {string n; logic [31:0] v; logic [31:0] m;} acalu_exp_t;
  logic mclk_i = 1'b0, rstn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, cf, rd_dp = 1'b0;
  logic [1:0] htrans_i = 2'h0, dly = 2'h0;
  logic [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000, hrdata_o, w32;
  logic [31:0] lfsr = 32'h0001_345c;
  logic hreadyout_o, hresp_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, ins, pcv, t;
  logic [15:0] ac [4];
  logic [17:0] res;
  logic [4:0] op;
  int bad_count = 0, checks_done = 0;
  acalu_exp_t exp_q [$];
  acalu_exp_t e;
  always #20 mclk_i = ~mclk_i;
  acalu_core dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));
  acalu_mem mem_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .dly_i(dly),
    .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));
  // ****
  // helpers
  // ****
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [17:0] arith(logic [15:0] i, logic [15:0] s, logic [15:0] d,
                                        logic c);
    logic ci, co;
    logic [16:0] w, a;
    ci = (i[5:4] == 2'h0) ? c : (i[5:4] == 2'h1) ? 1'b0 : (i[5:4] == 2'h2) ? 1'b1 : !c;
    co = ci;
    a = (i[10:8] == 3'h6) ? {1'b0, d} + {1'b0, s} : {1'b0, d} + {1'b0, ~s} + (i[10:8] == 3'h5);
    case (i[10:8])
      3'h0: w[15:0] = ~s;
      3'h1: w[15:0] = 16'h0000 - s;
      3'h2: w[15:0] = s;
      3'h3: w[15:0] = s + 16'h0001;
      3'h7: w[15:0] = s & d;
      default: w[15:0] = a[15:0];
    endcase
    if ((i[10:8] == 3'h1 && s == 16'h0000) || (i[10:8] == 3'h3 && s == 16'hffff) ||
        (i[10:8] inside {3'h4, 3'h5, 3'h6} && a[16])) co = !ci;
    w[16] = co;
    case (i[7:6])
      2'h1: w = {w[15:0], w[16]};
      2'h2: w = {w[0], w[16:1]};
      2'h3: w = {w[16], w[7:0], w[15:8]};
      default: ;
    endcase
    return {i[0] ^ ((i[2] && w[15:0] == 16'h0000) || (i[1] && !w[16])), w};
  endfunction
  task chk(string n, logic [31:0] v, logic [31:0] s);
    checks_done++;
    if (s !== v) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, v, s);
    end
  endtask
  task rdy();
    int k;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 99);
    if (k >= 99) chk("hready", 32'h1, 32'h0);
  endtask
  task ahb(logic wr, logic [7:0] a, logic [15:0] d, string n, logic [31:0] v,
           logic [31:0] m, output logic [31:0] q);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    haddr_i <= {24'h00_0000, a};
    rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {16'h0000, d};
    if (!wr) exp_q.push_back('{n, v, m});
    rdy();
    q = hrdata_o;
  endtask
  task wr(logic [7:0] a, logic [15:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, "", 32'h0, 32'h0, q);
  endtask
  task rd(string n, logic [7:0] a, logic [31:0] v, logic [31:0] m = 32'hffff_ffff);
    logic [31:0] q;
    ahb(1'b0, a, 16'h0000, n, v, m, q);
  endtask
  task exec(logic [15:0] i);
    logic [31:0] q;
    wr(`ACALU_A_INSTR, i);
    q = 32'h1;
    for (int k = 0; k < 60 && q[0] !== 1'b0; k++) ahb(1'b0, `ACALU_A_STATUS, 16'h0, "", 0, 0, q);
    chk("busy", 32'h0, {31'h0, q[0]});
  endtask
  task load();
    for (int k = 0; k < 4; k++) wr(8'(4 * k), ac[k]);
    wr(`ACALU_A_CARRY, {15'h0000, cf});
    wr(`ACALU_A_PC, pcv);
  endtask
  task check(string n);
    for (int k = 0; k < 4; k++) rd($sformatf("%s ac%0d", n, k), 8'(4 * k), {16'h0000, ac[k]});
    rd({n, " carry"}, `ACALU_A_CARRY, {31'h0, cf});
    rd({n, " pc"}, `ACALU_A_PC, {16'h0000, pcv});
  endtask
  task randomize_acs();
    for (int k = 0; k < 4; k++) ac[k] = 16'(rnd());
    pcv = 16'(rnd());
    dly <= 2'(rnd());
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****
  // read data monitor
  // ****
  always @(posedge mclk_i) begin
    if (rd_dp && hreadyout_o === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e.m != 32'h0) chk(e.n, e.v & e.m, hrdata_o & e.m);
    end
    if (hreadyout_o === 1'b1) rd_dp = hsel_i && htrans_i[1] && !hwrite_i;
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    chk("watchdog", 32'h1, 32'h0);
    test_done();
  end
  // ****
  // stimulus
  // ****
  initial begin
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    for (int k = 0; k < 12; k++) rd("reset", 8'(4 * k), 32'h0);
    $display("done reset");
    for (int i = 0; i < 512; i++) begin
      t = 16'(rnd());
      ins = {1'b1, t[3:0], i[2:0], i[4:3], i[6:5], t[4], i[2:0] ^ i[8:6]};
      randomize_acs();
      cf = t[5];
      if (i[8:7] == 2'h0) ac[ins[14:13]] = 16'h0000;
      if (i[8:7] == 2'h1) ac[ins[14:13]] = 16'hffff;
      load();
      res = arith(ins, ac[ins[14:13]], ac[ins[12:11]], cf);
      exec(ins);
      if (!ins[3]) begin
        ac[ins[12:11]] = res[15:0];
        cf = res[16];
      end
      pcv = pcv + 16'h0001 + 16'(res[17]);
      check("arith");
      rd("skip flag", `ACALU_A_STATUS, {29'h0, res[17], 2'h0}, 32'h4);
    end
    $display("done arith");
    randomize_acs();
    load();
    exec(16'h6210);
    {ac[0], ac[1]} = ac[1] * ac[2] + ac[0];
    pcv++;
    check("mul");
    for (int j = 0; j < 2; j++) begin
      randomize_acs();
      ac[2] = ac[2] | 16'h8000;
      ac[0] = (j == 1) ? ac[2] : ac[0] & 16'h7fff;
      load();
      exec(16'h6211);
      if (j == 0) begin
        t = 16'({ac[0], ac[1]} % ac[2]);
        ac[1] = 16'({ac[0], ac[1]} / ac[2]);
        ac[0] = t;
      end
      pcv = pcv + 16'h0001 + 16'(j == 0);
      check("div");
    end
    for (int j = 0; j < 2; j++) begin
      randomize_acs();
      ac[1][3:0] = 4'hb;
      load();
      exec({12'h600, (j == 1) ? 4'h5 : 4'h0});
      w32 = {ac[0], ac[0]} << ((j == 1) ? 5 : 11);
      ac[0] = w32[31:16];
      pcv++;
      check("rotl");
    end
    for (int j = 0; j < 2; j++) begin
      randomize_acs();
      t = ((j == 1) ? ac[2] : pcv) + 16'hfffc;
      w32 = rnd();
      mem_u.mem[t] = t ^ 16'h8000;
      mem_u.mem[t ^ 16'h8000] = w32[15:0];
      load();
      exec({(j == 1) ? 8'h6a : 8'h69, 8'hfc});
      ac[3] = pcv + 16'h0001;
      pcv = w32[15:0];
      check("call");
    end
    for (int k = 0; k < 16; k++) mem_u.mem[16'h0130 + k] = 16'((32'h2 << k) - 1);
    for (int j = 0; j < 3; j++) begin
      op = (j == 0) ? 5'h0e : (j == 1) ? 5'h1f : 5'h02;
      randomize_acs();
      if (j == 0) begin
        ac[0] = 16'h3fda;
        ac[3] = 16'h2041;
        mem_u.mem[ac[2] + 16'h0034] = 16'h0026;
        mem_u.mem[ac[2] + 16'h0035] = 16'h0005;
      end
      w32 = rnd();
      mem_u.mem[16'h0158 + op] = w32[15:0];
      load();
      exec({3'h3, op, 8'h34});
      chk("trap slot", {16'h0000, pcv + 16'h0001}, {16'h0000, mem_u.mem[16'h0157]});
      pcv = w32[15:0];
      check("trap");
    end
    $display("done misc");
    wr(`ACALU_A_CTRL, 16'h0001);
    rd("ctrl", `ACALU_A_CTRL, 32'h1);
    mem_u.mem[16'h0157] = 16'h0000;
    exec(16'h7b05);
    pcv++;
    check("ram trap");
    rd("l reg", `ACALU_A_LREG, 32'h7b05);
    rd("x reg", `ACALU_A_SWAPPED_INSTR_REG, 32'h057b);
    rd("ram flag", `ACALU_A_STATUS, 32'h2, 32'h2);
    chk("ram slot", 32'h0, {16'h0000, mem_u.mem[16'h0157]});
    $display("done ram trap");
    test_done();
  end
endmodule
